// >>> verilog/hb_map_pkg.sv
// constants, encodings and register map of the half-bridge state and input map
// assumes a single 20 MHz clock shared by every module that imports it
package hb_map_pkg;
	localparam int NUM_BRIDGES = 8;
	localparam int NUM_INPUTS = 4;
	localparam int FIELDS_PER_REG = 4;
	localparam int FIELD_W = 2;
	localparam int REG_W = 8;
	localparam int ADDR_W = 8;

	localparam logic [ADDR_W-1:0] ADDR_BRIDGE_STATE_UPPER = 8'h0a;
	localparam logic [ADDR_W-1:0] ADDR_SOURCE_MAP_LOWER = 8'h0b;
	localparam logic [ADDR_W-1:0] ADDR_SOURCE_MAP_UPPER = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_DRIVE_SIDE_SELECT = 8'h0d;
	localparam logic [ADDR_W-1:0] ADDR_FREEWHEEL_SELECT = 8'h0e;

	localparam logic [REG_W-1:0] RESET_BRIDGE_STATE_UPPER = 8'h00;
	localparam logic [REG_W-1:0] RESET_SOURCE_MAP_LOWER = 8'h05;
	localparam logic [REG_W-1:0] RESET_SOURCE_MAP_UPPER = 8'haf;
	localparam logic [REG_W-1:0] RESET_DRIVE_SIDE_SELECT = 8'h00;
	localparam logic [REG_W-1:0] RESET_FREEWHEEL_SELECT = 8'h00;
	localparam logic [REG_W-1:0] READ_UNMAPPED = 8'h00;

	typedef enum logic [1:0] {
		TRISTATE_OFF = 2'b00,
		SINK_ON_STATE = 2'b01,
		SOURCE_ON_STATE = 2'b10,
		PULSE_MODE = 2'b11
	} bridge_mode_t;

	localparam logic SIDE_LOW = 1'b1;
	localparam logic FREEWHEEL_PASSIVE = 1'b1;

	localparam int CLK_PERIOD_NS = 50;
	localparam int DEAD_TIME_NS = 200;
	localparam int DEAD_CYCLES_RAW = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEAD_CYCLES = (DEAD_CYCLES_RAW < 1) ? 1 : DEAD_CYCLES_RAW;
	localparam int DEAD_CNT_W = 4;
	localparam logic [DEAD_CNT_W-1:0] DEAD_COUNT = DEAD_CYCLES[DEAD_CNT_W-1:0];
	localparam logic [DEAD_CNT_W-1:0] DEAD_ZERO = 4'h0;
	localparam logic [DEAD_CNT_W-1:0] DEAD_ONE = 4'h1;
endpackage

// >>> verilog/gate_cmd_if.sv
// requested gate levels per bridge, from the mapping logic to the dead-time stage
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface gate_cmd_if #(parameter int BRIDGES = 8);
	logic [BRIDGES-1:0] wantUpper;
	logic [BRIDGES-1:0] wantLower;
	modport source (output wantUpper, output wantLower);
	modport sink (input wantUpper, input wantLower);
endinterface

// >>> verilog/pulse_sync.sv
// two-stage synchroniser for the external pulse inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/1ns
module pulse_sync #(
	parameter int WIDTH = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_state_t;

	sync_state_t s;
	sync_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.stage1 = asyncIn;
		next_s.stage2 = s.stage1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign syncOut = s.stage2;
endmodule

// >>> verilog/gate_dead_time.sv
// gate output stage: registers requested levels and inserts dead time
// assumes requests never ask for both gates of one bridge at once
`timescale 1ns/1ns
module gate_dead_time
	import hb_map_pkg::*;
#(
	parameter int BRIDGES = 8
) (
	input wire logic clk,
	input wire logic rst,
	gate_cmd_if.sink cmd,
	output logic [BRIDGES-1:0] upperGate,
	output logic [BRIDGES-1:0] lowerGate
);
	typedef struct packed {
		logic [BRIDGES-1:0] upper;
		logic [BRIDGES-1:0] lower;
		logic [BRIDGES-1:0][DEAD_CNT_W-1:0] dead;
	} dead_state_t;

	dead_state_t s;
	dead_state_t next_s;

	always_comb begin
		next_s = s;
		for (int i = 0; i < BRIDGES; i++) begin
			if ((s.upper[i] && !cmd.wantUpper[i]) || (s.lower[i] && !cmd.wantLower[i])) begin
				// release first, then wait before any gate turns on
				next_s.upper[i] = s.upper[i] & cmd.wantUpper[i];
				next_s.lower[i] = s.lower[i] & cmd.wantLower[i];
				next_s.dead[i] = DEAD_COUNT;
			end else if (s.dead[i] != DEAD_ZERO) begin
				next_s.dead[i] = s.dead[i] - DEAD_ONE;
			end else begin
				next_s.upper[i] = cmd.wantUpper[i];
				next_s.lower[i] = cmd.wantLower[i];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign upperGate = s.upper;
	assign lowerGate = s.lower;
endmodule

// >>> verilog/half_bridge_map.sv
// register bank and pulse routing for eight half-bridge gate drivers
// assumes a register port on clk and asynchronous pulse inputs
`timescale 1ns/1ns

module half_bridge_map
	import hb_map_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [hb_map_pkg::ADDR_W-1:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [hb_map_pkg::REG_W-1:0] regWriteData,
	output logic [hb_map_pkg::REG_W-1:0] regReadData,
	input wire logic [hb_map_pkg::REG_W-1:0] lowerBridgeState,
	input wire logic pulseInputA,
	input wire logic pulseInputB,
	input wire logic pulseInputC,
	input wire logic pulseInputD,
	output logic [hb_map_pkg::NUM_BRIDGES-1:0] upperGate,
	output logic [hb_map_pkg::NUM_BRIDGES-1:0] lowerGate
);
	import hb_map_pkg::*;

	typedef struct packed {
		logic [REG_W-1:0] bridgeStateUpper;
		logic [REG_W-1:0] inputSourceMapLower;
		logic [REG_W-1:0] inputSourceMapUpper;
		logic [REG_W-1:0] driveSideSelect;
		logic [REG_W-1:0] freewheelSelect;
		logic [REG_W-1:0] readData;
	} map_state_t;

	map_state_t s;
	map_state_t next_s;
	logic [NUM_INPUTS-1:0] pulseSync;
	logic [NUM_BRIDGES-1:0] bridgeWantUpper;
	logic [NUM_BRIDGES-1:0] bridgeWantLower;

	gate_cmd_if #(.BRIDGES(NUM_BRIDGES)) gateCmd ();

	// field of bridge idx within a four-field register, first bridge at the top
	function automatic logic [FIELD_W-1:0] fieldOf(input logic [REG_W-1:0] value, input int idx);
		logic [FIELD_W-1:0] result;
		result = value[(REG_W - 1 - FIELD_W * idx) -: FIELD_W];
		return result;
	endfunction

	// per-bridge flag, bridge one at bit 7
	function automatic logic bitOf(input logic [REG_W-1:0] value, input int idx);
		logic result;
		result = value[REG_W - 1 - idx];
		return result;
	endfunction

	pulse_sync #(.WIDTH(NUM_INPUTS)) inputSync (
		.clk(clk),
		.rst(rst),
		.asyncIn({pulseInputD, pulseInputC, pulseInputB, pulseInputA}),
		.syncOut(pulseSync)
	);

	// register port and readback
	always_comb begin
		next_s = s;
		if (regWrite) begin
			unique case (regAddr)
				ADDR_BRIDGE_STATE_UPPER: next_s.bridgeStateUpper = regWriteData;
				ADDR_SOURCE_MAP_LOWER: next_s.inputSourceMapLower = regWriteData;
				ADDR_SOURCE_MAP_UPPER: next_s.inputSourceMapUpper = regWriteData;
				ADDR_DRIVE_SIDE_SELECT: next_s.driveSideSelect = regWriteData;
				ADDR_FREEWHEEL_SELECT: next_s.freewheelSelect = regWriteData;
				default: next_s.bridgeStateUpper = s.bridgeStateUpper;
			endcase
		end
		if (regRead) begin
			unique case (regAddr)
				ADDR_BRIDGE_STATE_UPPER: next_s.readData = s.bridgeStateUpper;
				ADDR_SOURCE_MAP_LOWER: next_s.readData = s.inputSourceMapLower;
				ADDR_SOURCE_MAP_UPPER: next_s.readData = s.inputSourceMapUpper;
				ADDR_DRIVE_SIDE_SELECT: next_s.readData = s.driveSideSelect;
				ADDR_FREEWHEEL_SELECT: next_s.readData = s.freewheelSelect;
				default: next_s.readData = READ_UNMAPPED;
			endcase
		end
	end

	// gate requests per bridge, straight from the live registers and, for bridges one to four, the lowerBridgeState input
	always_comb begin
		logic [FIELD_W-1:0] mode;
		logic [FIELD_W-1:0] source;
		logic pulse;
		logic sideLow;
		logic passive;
		mode = '0;
		source = '0;
		pulse = 1'b0;
		sideLow = 1'b0;
		passive = 1'b0;
		bridgeWantUpper = '0;
		bridgeWantLower = '0;
		for (int i = 0; i < NUM_BRIDGES; i++) begin
			if (i < FIELDS_PER_REG) begin
				mode = fieldOf(lowerBridgeState, i);
				source = fieldOf(s.inputSourceMapLower, i);
			end else begin
				mode = fieldOf(s.bridgeStateUpper, i - FIELDS_PER_REG);
				source = fieldOf(s.inputSourceMapUpper, i - FIELDS_PER_REG);
			end
			pulse = pulseSync[source];
			sideLow = bitOf(s.driveSideSelect, i) == SIDE_LOW;
			passive = bitOf(s.freewheelSelect, i) == FREEWHEEL_PASSIVE;
			unique case (bridge_mode_t'(mode))
				TRISTATE_OFF: begin
					bridgeWantUpper[i] = 1'b0;
					bridgeWantLower[i] = 1'b0;
				end
				SINK_ON_STATE: begin
					bridgeWantUpper[i] = 1'b0;
					bridgeWantLower[i] = 1'b1;
				end
				SOURCE_ON_STATE: begin
					bridgeWantUpper[i] = 1'b1;
					bridgeWantLower[i] = 1'b0;
				end
				PULSE_MODE: begin
					if (sideLow) begin
						bridgeWantLower[i] = pulse;
						bridgeWantUpper[i] = !passive && !pulse;
					end else begin
						bridgeWantUpper[i] = pulse;
						bridgeWantLower[i] = !passive && !pulse;
					end
				end
			endcase
		end
	end

	assign gateCmd.wantUpper = bridgeWantUpper;
	assign gateCmd.wantLower = bridgeWantLower;

	gate_dead_time #(.BRIDGES(NUM_BRIDGES)) gateStage (
		.clk(clk),
		.rst(rst),
		.cmd(gateCmd.sink),
		.upperGate(upperGate),
		.lowerGate(lowerGate)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s.bridgeStateUpper <= RESET_BRIDGE_STATE_UPPER;
			s.inputSourceMapLower <= RESET_SOURCE_MAP_LOWER;
			s.inputSourceMapUpper <= RESET_SOURCE_MAP_UPPER;
			s.driveSideSelect <= RESET_DRIVE_SIDE_SELECT;
			s.freewheelSelect <= RESET_FREEWHEEL_SELECT;
			s.readData <= READ_UNMAPPED;
		end else begin
			s <= next_s;
		end
	end

	assign regReadData = s.readData;
endmodule

// >>> verif/half_bridge_map_properties.sv
// port assertions for the half-bridge state and input map
// assumes bound to half_bridge_map, single clock domain
`timescale 1ns/1ns
module half_bridge_map_properties
	import hb_map_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [hb_map_pkg::ADDR_W-1:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [hb_map_pkg::REG_W-1:0] regWriteData,
	input wire logic [hb_map_pkg::REG_W-1:0] regReadData,
	input wire logic [hb_map_pkg::NUM_BRIDGES-1:0] upperGate,
	input wire logic [hb_map_pkg::NUM_BRIDGES-1:0] lowerGate
);
	logic [7:0] sh [5];
	logic inMap;
	logic [7:0] rdExp;
	assign inMap = regAddr >= 8'h0a && regAddr <= 8'h0e;
	assign rdExp = inMap ? sh[3'(regAddr - 8'h0a)] : 8'h00;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sh <= '{8'h00, 8'h05, 8'haf, 8'h00, 8'h00};
		end else if (regWrite && inMap) begin
			sh[3'(regAddr - 8'h0a)] <= regWriteData;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_no_shoot_through: assert property (!(|(upperGate & lowerGate))) else $error("both gates on");
	a_gates_off_reset: assert property ($fell(rst) |-> upperGate == 8'h00 && lowerGate == 8'h00)
		else $error("gates on after reset");
	a_read_mapped: assert property (regRead && inMap |=> regReadData == $past(rdExp))
		else $error("read data wrong");
	a_read_unmapped: assert property (regRead && !inMap |=> regReadData == 8'h00)
		else $error("unmapped read not zero");
	a_read_holds: assert property (!regRead |=> $stable(regReadData)) else $error("read data moved");
	a_state_off: assert property (sh[0][3:2] == 2'b00 [*3] |-> !upperGate[6] && !lowerGate[6])
		else $error("bridge g not off");
	a_state_low: assert property (sh[0][7:6] == 2'b01 [*8] |-> lowerGate[4] && !upperGate[4])
		else $error("bridge e not low");
	a_state_high: assert property (sh[0][1:0] == 2'b10 [*8] |-> upperGate[7] && !lowerGate[7])
		else $error("bridge h not high");
	a_dead_time: assert property ($fell(upperGate[4]) |-> !lowerGate[4] [*4])
		else $error("dead time short");
	a_dead_time_low: assert property ($fell(lowerGate[4]) |-> !upperGate[4] [*4])
		else $error("dead time short after lower gate");
endmodule
bind half_bridge_map half_bridge_map_properties i_props (.clk(clk), .rst(rst), .regAddr(regAddr),
	.regWrite(regWrite), .regRead(regRead), .regWriteData(regWriteData), .regReadData(regReadData),
	.upperGate(upperGate), .lowerGate(lowerGate));

// >>> verif/pulse_source.sv
// host-side source of the four external pulse inputs
// assumes levels come from the bench; edges land off the clock grid
`timescale 1ns/1ns
module pulse_source (
	input wire logic [3:0] level,
	input wire logic slow,
	output logic [3:0] pulse
);
	initial pulse = 4'h0;
	always @(level) begin
		if (slow) begin
			pulse <= #37 level;
		end else begin
			pulse <= #7 level;
		end
	end
endmodule

// >>> verif/testbench.sv
// self-checking bench for the half-bridge state and input map
// assumes the checker is bound by its own file
`timescale 1ns/1ns
module testbench;
	import hb_map_pkg::*;
	logic clk = 0, rst = 1, regWrite = 0, regRead = 0, slow = 0, rdSeen = 0, gChk = 0;
	logic [7:0] regAddr = 0, regWriteData = 0, regReadData, lowerBridgeState = 0, upperGate, lowerGate;
	logic [3:0] level = 0, pulse;
	logic [7:0] r [5];
	logic [15:0] q [$];
	logic [15:0] want, got;
	int miscompares = 0, total_checks = 0;
	always #25 clk = ~clk;
	pulse_source i_src (.level(level), .slow(slow), .pulse(pulse));
	half_bridge_map i_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
		.regWriteData(regWriteData), .regReadData(regReadData), .lowerBridgeState(lowerBridgeState),
		.pulseInputA(pulse[0]), .pulseInputB(pulse[1]), .pulseInputC(pulse[2]), .pulseInputD(pulse[3]),
		.upperGate(upperGate), .lowerGate(lowerGate));
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic acc(logic w, logic rd, logic [7:0] a, logic [7:0] d);
		regWrite = w;
		regRead = rd;
		regAddr = a;
		regWriteData = d;
		@(negedge clk);
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		q.push_back({8'h00, e});
		acc(1'b0, 1'b1, a, 8'h00);
	endtask
	function automatic logic [15:0] gexp();
		logic [7:0] u, l;
		logic [1:0] st, sr;
		u = 8'h00;
		l = 8'h00;
		for (int b = 0; b < 8; b++) begin
			st = b < 4 ? lowerBridgeState[7-2*b -: 2] : r[0][15-2*b -: 2];
			sr = b < 4 ? r[1][7-2*b -: 2] : r[2][15-2*b -: 2];
			case (st)
				2'b01: l[b] = 1'b1;
				2'b10: u[b] = 1'b1;
				2'b11: begin
					u[b] = r[3][7-b] ? !r[4][7-b] && !level[sr] : level[sr];
					l[b] = r[3][7-b] ? level[sr] : !r[4][7-b] && !level[sr];
				end
				default: ;
			endcase
		end
		return {u, l};
	endfunction
	task automatic gchk();
		q.push_back(gexp());
		gChk <= 1'b1;
		@(negedge clk);
		gChk <= 1'b0;
	endtask
	always @(posedge clk) rdSeen <= regRead;
	always @(negedge clk) begin
		if (rdSeen || gChk) begin
			got = rdSeen ? {8'h00, regReadData} : {upperGate, lowerGate};
			want = q.size() > 0 ? q.pop_front() : 16'hxxxx;
			total_checks++;
			if (got !== want) begin
				miscompares++;
				$display("[ERR] %s exp %h got %h", rdSeen ? "readData" : "gates", want, got);
			end
		end
	end
	initial begin
		#5000000;
		miscompares++;
		close_out();
	end
	initial begin
		void'($urandom(13));
		repeat (10) @(negedge clk);
		rst = 0;
		r = '{8'h00, 8'h05, 8'haf, 8'h00, 8'h00};
		for (int i = 0; i < 6; i++) rd(8'h0a + 8'(i), i < 5 ? r[i] : 8'h00);
		acc(1'b0, 1'b0, 8'h00, 8'h00);
		gchk();
		$display("test reset_values done");
		for (int n = 0; n < 40; n++) begin
			slow = n[0];
			lowerBridgeState = 8'($urandom);
			level = 4'($urandom);
			for (int i = 0; i < 5; i++) begin
				r[i] = 8'($urandom);
				acc(1'b1, 1'b0, 8'h0a + 8'(i), r[i]);
			end
			for (int i = 0; i < 5; i++) rd(8'h0a + 8'(i), r[i]);
			acc(1'b0, 1'b0, 8'h00, 8'h00);
			repeat (12) @(negedge clk);
			gchk();
		end
		$display("test random_map done");
		close_out();
	end
endmodule
